// File: verilog/eeprom_host_pkg.sv
// Constants for the paged parallel EEPROM host controller.
// Assumes a 25 MHz system clock and a single AHB-Lite master.
`default_nettype none
package eeprom_host_pkg;
   localparam int ADDR_W      = 15;
   localparam int DATA_W      = 8;
   localparam int PAGE_LSB    = 6;
   localparam int PAGE_BYTES  = 64;
   localparam int TIMER_W     = 18;

   // Timing, figures in their own units
   localparam int CLK_NS      = 40;
   localparam int WP_NS       = 100;
   localparam int WPH_NS      = 50;
   localparam int ACC_NS      = 150;
   localparam int SYNC_STAGES = 2;
   localparam int BLC_US      = 150;
   localparam int WC_MS       = 10;
   localparam int WP_CYC      = (WP_NS + CLK_NS - 1) / CLK_NS;
   localparam int WPH_CYC     = (WPH_NS + CLK_NS - 1) / CLK_NS;
   localparam int ACC_CYC     = (ACC_NS + CLK_NS - 1) / CLK_NS;
   localparam int READ_CYC    = ACC_CYC + SYNC_STAGES;
   localparam int BLC_CYC     = (BLC_US * 1000) / CLK_NS;
   localparam int WC_CYC      = (WC_MS * 1000 * 1000 + CLK_NS - 1) / CLK_NS;

   // Register byte offsets
   localparam logic [7:0] REG_CMD    = 8'h00;
   localparam logic [7:0] REG_ADDR   = 8'h04;
   localparam logic [7:0] REG_WDATA  = 8'h08;
   localparam logic [7:0] REG_CONFIG = 8'h0C;
   localparam logic [7:0] REG_STATUS = 8'h10;
   localparam logic [7:0] REG_RDATA  = 8'h14;

   // Command codes written to REG_CMD
   localparam logic [2:0] CMD_READ     = 3'h1;
   localparam logic [2:0] CMD_LOAD     = 3'h2;
   localparam logic [2:0] CMD_GUARD_ON = 3'h3;

   // Field positions
   localparam int CFG_PREFIX  = 0;
   localparam int CFG_IDSEL   = 1;
   localparam int ST_BUSY     = 0;
   localparam int ST_OPEN     = 1;
   localparam int ST_DONE     = 8;
   localparam int ST_ERR_PAGE = 9;
   localparam int ST_ERR_TIME = 10;
   localparam int ST_ERR_BUSY = 11;
   localparam int POLL_BIT    = 7;
   localparam int TOGGLE_BIT  = 6;

   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [2:0] HSIZE_WORD    = 3'h2;

   // Three-write guard command sequence
   function automatic logic [ADDR_W-1:0] guardAddr(input logic [1:0] idx);
      return (idx == 2'h1) ? 15'h2AAA : 15'h5555;
   endfunction

   function automatic logic [DATA_W-1:0] guardData(input logic [1:0] idx);
      case (idx)
         2'h0:    return 8'hAA;
         2'h1:    return 8'h55;
         default: return 8'hA0;
      endcase
   endfunction
endpackage
`default_nettype wire

// File: verilog/eeprom_cycle_if.sv
// One pin-level bus cycle request between sequencer and pin driver.
// Assumes both ends share clk; start and done are one-cycle pulses.
`default_nettype none
interface eeprom_cycle_if;
   import eeprom_host_pkg::*;
   logic              start;
   logic              write;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdata;
   logic [DATA_W-1:0] rdata;
   logic              done;
   modport ctrl (output start, write, addr, wdata, input rdata, done);
   modport pins (input start, write, addr, wdata, output rdata, done);
endinterface
`default_nettype wire

// File: verilog/eeprom_pin_cycle.sv
// Pin driver: runs one strobed write or one read on the EEPROM pins.
// Assumes start only while idle; dataIn is asynchronous to clk.
`default_nettype none
module eeprom_pin_cycle
   import eeprom_host_pkg::*;
(
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              rst,
   // Request side
   eeprom_cycle_if.pins           cyc,
   // Memory pins
   output var  logic              ceN,
   output var  logic              oeN,
   output var  logic              weN,
   output var  logic [ADDR_W-1:0] addrPin,
   output var  logic [DATA_W-1:0] dataOut,
   output var  logic              dataOe,
   input  wire logic [DATA_W-1:0] dataIn
);
   typedef enum logic [2:0] {P_IDLE, P_SETUP, P_STROBE, P_RECOVER, P_READ} pin_state_e;

   pin_state_e        state_q;
   logic [3:0]        cnt_q;
   logic [DATA_W-1:0] sync1_q;
   logic [DATA_W-1:0] sync2_q;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sync1_q <= '0;
         sync2_q <= '0;
      end else begin
         sync1_q <= dataIn;
         sync2_q <= sync1_q;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_q   <= P_IDLE;
         cnt_q     <= '0;
         ceN       <= 1'b1;
         oeN       <= 1'b1;
         weN       <= 1'b1;
         dataOe    <= 1'b0;
         addrPin   <= '0;
         dataOut   <= '0;
         cyc.done  <= 1'b0;
         cyc.rdata <= '0;
      end else begin
         cyc.done <= 1'b0;
         case (state_q)
            P_IDLE: begin
               if (cyc.start) begin
                  addrPin <= cyc.addr;
                  dataOut <= cyc.wdata;
                  ceN     <= 1'b0;
                  if (cyc.write) begin
                     // Output drive held high through the strobe
                     oeN     <= 1'b1;
                     dataOe  <= 1'b1;
                     state_q <= P_SETUP;
                  end else begin
                     oeN     <= 1'b0;
                     cnt_q   <= 4'(READ_CYC - 1);
                     state_q <= P_READ;
                  end
               end
            end
            P_SETUP: begin
               // Strobe far wider than the noise filter
               weN     <= 1'b0;
               cnt_q   <= 4'(WP_CYC - 1);
               state_q <= P_STROBE;
            end
            P_STROBE: begin
               if (cnt_q == '0) begin
                  weN     <= 1'b1;
                  cnt_q   <= 4'(WPH_CYC - 1);
                  state_q <= P_RECOVER;
               end else begin
                  cnt_q <= cnt_q - 4'h1;
               end
            end
            P_RECOVER: begin
               ceN    <= 1'b1;
               dataOe <= 1'b0;
               if (cnt_q == '0) begin
                  cyc.done <= 1'b1;
                  state_q  <= P_IDLE;
               end else begin
                  cnt_q <= cnt_q - 4'h1;
               end
            end
            P_READ: begin
               if (cnt_q == '0) begin
                  cyc.rdata <= sync2_q;
                  cyc.done  <= 1'b1;
                  ceN       <= 1'b1;
                  oeN       <= 1'b1;
                  state_q   <= P_IDLE;
               end else begin
                  cnt_q <= cnt_q - 4'h1;
               end
            end
            default: state_q <= P_IDLE;
         endcase
      end
   end
endmodule
`default_nettype wire

// File: verilog/eeprom_host.sv
// Host controller for a paged parallel EEPROM, driven over AHB-Lite.
// Assumes one AHB master, word transfers only, and the memory on its pins.
//
// Function
// - Write is a strobe low pulse with select low, output drive high.
// - Host starts each further byte within 150 us of the previous.
// - Host keeps page address bits identical throughout one page load.
// - Guard starts off; three command writes enable it after write time.
// - With guard on, writes need the three-write prefix before data.
// - Command writes follow page-load timing and are not stored.
`default_nettype none
module eeprom_host
   import eeprom_host_pkg::*;
#(
   parameter int BLC_CYCLES = BLC_CYC,
   parameter int WC_CYCLES  = WC_CYC
) (
   // Clock and reset
   input  wire logic                 clk,
   input  wire logic                 rst,
   // AHB-Lite slave
   input  wire logic                 hsel,
   input  wire logic [31:0]          haddr,
   input  wire logic [1:0]           htrans,
   input  wire logic                 hwrite,
   input  wire logic [2:0]           hsize,
   input  wire logic [31:0]          hwdata,
   input  wire logic                 hready,
   output var  logic                 hreadyout,
   output var  logic [31:0]          hrdata,
   output var  logic                 hresp,
   // Memory pins
   output var  logic                 ceN,
   output var  logic                 oeN,
   output var  logic                 weN,
   output var  logic [ADDR_W-1:0]    addrPin,
   output var  logic [DATA_W-1:0]    dataOut,
   output var  logic                 dataOe,
   input  wire logic [DATA_W-1:0]    dataIn,
   output var  logic                 idSelect
);
   if (BLC_CYCLES < 16 || BLC_CYCLES >= 2**TIMER_W) begin : g_chk_blc
      $error("BLC_CYCLES out of range");
   end
   if (WC_CYCLES < 16 || WC_CYCLES >= 2**TIMER_W) begin : g_chk_wc
      $error("WC_CYCLES out of range");
   end

   typedef enum logic [2:0] {S_IDLE, S_READ, S_PREFIX, S_LOAD, S_OPEN, S_POLL, S_WAITWC} host_state_e;

   eeprom_cycle_if cyc ();

   host_state_e             state_q;
   logic                    wrEn_q;
   logic [7:0]              regAddr_q;
   logic [ADDR_W-1:0]       addr_q;
   logic [DATA_W-1:0]       wdata_q;
   logic [DATA_W-1:0]       rdata_q;
   logic [1:0]              config_q;
   logic [3:0]              sticky_q;
   logic [ADDR_W-PAGE_LSB-1:0] page_q;
   logic [ADDR_W-1:0]       lastAddr_q;
   logic [DATA_W-1:0]       lastData_q;
   logic                    dataLoaded_q;
   logic                    guardOnly_q;
   logic [1:0]              step_q;
   logic                    pending_q;
   logic                    havePrev_q;
   logic                    prevToggle_q;
   logic [TIMER_W-1:0]      timer_q;
   logic                    busy;
   logic                    cmdWr;
   logic [2:0]              cmdCode;
   logic                    doneEv;
   logic                    errPageEv;
   logic                    errTimeEv;
   logic                    errBusyEv;
   logic                    cmdAccepted;

   function automatic logic [31:0] regRead(input logic [7:0] off, input logic [31:0] status);
      case (off)
         REG_ADDR:   regRead = {17'h0_0000, addr_q};
         REG_WDATA:  regRead = {24'h00_0000, wdata_q};
         REG_CONFIG: regRead = {30'h0000_0000, config_q};
         REG_STATUS: regRead = status;
         REG_RDATA:  regRead = {24'h00_0000, rdata_q};
         default:    regRead = 32'h0000_0000;
      endcase
   endfunction

   assign busy    = (state_q != S_IDLE);
   assign cmdWr   = wrEn_q && (regAddr_q == REG_CMD);
   assign cmdCode = hwdata[2:0];
   assign cmdAccepted = cmdWr && (state_q == S_IDLE || (state_q == S_OPEN && cmdCode == CMD_LOAD));
   assign errBusyEv   = cmdWr && !cmdAccepted && (cmdCode != 3'h0);
   // Every byte of one load must share the page bits
   assign errPageEv   = cmdWr && state_q == S_OPEN && cmdCode == CMD_LOAD
                        && addr_q[ADDR_W-1:PAGE_LSB] != page_q;

   // AHB-Lite slave: zero wait states, always OKAY
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wrEn_q    <= 1'b0;
         regAddr_q <= '0;
         hrdata    <= '0;
         hreadyout <= 1'b0;
         hresp     <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         wrEn_q    <= 1'b0;
         if (hsel && htrans == HTRANS_NONSEQ && hready && hsize == HSIZE_WORD) begin
            wrEn_q    <= hwrite;
            regAddr_q <= {haddr[7:2], 2'h0};
            hrdata    <= regRead({haddr[7:2], 2'h0},
                                 {20'h0_0000, sticky_q, 6'h00, (state_q == S_OPEN), busy});
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         addr_q   <= '0;
         wdata_q  <= '0;
         config_q <= '0;
         idSelect <= 1'b0;
      end else begin
         if (wrEn_q && regAddr_q == REG_ADDR) addr_q <= hwdata[ADDR_W-1:0];
         if (wrEn_q && regAddr_q == REG_WDATA) wdata_q <= hwdata[DATA_W-1:0];
         if (wrEn_q && regAddr_q == REG_CONFIG) config_q <= hwdata[1:0];
         // Enables the external high-voltage switch on the id pin
         idSelect <= config_q[CFG_IDSEL];
      end
   end

   // Sticky flags, write one to clear; a same-cycle event wins
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sticky_q <= '0;
      end else begin
         sticky_q <= (sticky_q & ~((wrEn_q && regAddr_q == REG_STATUS) ? hwdata[ST_ERR_BUSY:ST_DONE] : 4'h0))
                     | {errBusyEv, errTimeEv, errPageEv, doneEv};
      end
   end

   // Sequencer
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_q      <= S_IDLE;
         page_q       <= '0;
         lastAddr_q   <= '0;
         lastData_q   <= '0;
         dataLoaded_q <= 1'b0;
         guardOnly_q  <= 1'b0;
         step_q       <= '0;
         pending_q    <= 1'b0;
         havePrev_q   <= 1'b0;
         prevToggle_q <= 1'b0;
         timer_q      <= '0;
         rdata_q      <= '0;
         doneEv       <= 1'b0;
         errTimeEv    <= 1'b0;
         cyc.start    <= 1'b0;
         cyc.write    <= 1'b0;
         cyc.addr     <= '0;
         cyc.wdata    <= '0;
      end else begin
         doneEv    <= 1'b0;
         errTimeEv <= 1'b0;
         cyc.start <= 1'b0;
         if (cyc.done) pending_q <= 1'b0;
         case (state_q)
            S_IDLE: begin
               step_q       <= '0;
               dataLoaded_q <= 1'b0;
               if (cmdAccepted) begin
                  page_q      <= addr_q[ADDR_W-1:PAGE_LSB];
                  guardOnly_q <= (cmdCode == CMD_GUARD_ON);
                  case (cmdCode)
                     CMD_READ:     state_q <= S_READ;
                     // Guarded writes get the prefix first
                     CMD_LOAD:     state_q <= config_q[CFG_PREFIX] ? S_PREFIX : S_LOAD;
                     CMD_GUARD_ON: state_q <= S_PREFIX;
                     default:      state_q <= S_IDLE;
                  endcase
               end
            end
            S_READ: begin
               if (!pending_q) begin
                  cyc.start <= 1'b1;
                  cyc.write <= 1'b0;
                  cyc.addr  <= addr_q;
                  pending_q <= 1'b1;
               end else if (cyc.done) begin
                  rdata_q <= cyc.rdata;
                  doneEv  <= 1'b1;
                  state_q <= S_IDLE;
               end
            end
            S_PREFIX: begin
               // Enable sequence as one page load
               if (!pending_q) begin
                  cyc.start <= 1'b1;
                  cyc.write <= 1'b1;
                  cyc.addr  <= guardAddr(step_q);
                  cyc.wdata <= guardData(step_q);
                  pending_q <= 1'b1;
               end else if (cyc.done) begin
                  step_q <= step_q + 2'h1;
                  if (step_q == 2'h2) begin
                     timer_q <= '0;
                     state_q <= guardOnly_q ? S_OPEN : S_LOAD;
                  end
               end
            end
            S_LOAD: begin
               if (!pending_q) begin
                  cyc.start <= 1'b1;
                  cyc.write <= 1'b1;
                  cyc.addr  <= addr_q;
                  cyc.wdata <= wdata_q;
                  pending_q <= 1'b1;
               end else if (cyc.done) begin
                  lastAddr_q   <= cyc.addr;
                  lastData_q   <= cyc.wdata;
                  dataLoaded_q <= 1'b1;
                  timer_q      <= '0;
                  state_q      <= S_OPEN;
               end
            end
            S_OPEN: begin
               timer_q <= timer_q + TIMER_W'(1);
               if (cmdAccepted && !errPageEv) begin
                  // Next byte started inside the load window
                  state_q <= S_LOAD;
               end else if (timer_q == TIMER_W'(BLC_CYCLES - 1)) begin
                  // Load window lapsed, memory now programming
                  timer_q    <= '0;
                  havePrev_q <= 1'b0;
                  state_q    <= dataLoaded_q ? S_POLL : S_WAITWC;
               end
            end
            S_POLL: begin
               timer_q <= timer_q + TIMER_W'(1);
               if (timer_q == TIMER_W'(WC_CYCLES - 1)) begin
                  // Write cycle longer than its worst case
                  errTimeEv <= 1'b1;
                  doneEv    <= 1'b1;
                  state_q   <= S_IDLE;
               end else if (!pending_q) begin
                  cyc.start <= 1'b1;
                  cyc.write <= 1'b0;
                  cyc.addr  <= lastAddr_q;
                  pending_q <= 1'b1;
               end else if (cyc.done) begin
                  havePrev_q   <= 1'b1;
                  prevToggle_q <= cyc.rdata[TOGGLE_BIT];
                  // Finished when bit 7 matches the loaded byte and bit 6 is still
                  if (cyc.rdata[POLL_BIT] == lastData_q[POLL_BIT] && havePrev_q
                      && cyc.rdata[TOGGLE_BIT] == prevToggle_q) begin
                     rdata_q <= cyc.rdata;
                     doneEv  <= 1'b1;
                     state_q <= S_IDLE;
                  end
               end
            end
            S_WAITWC: begin
               // No data byte to poll, so wait out the full write time
               timer_q <= timer_q + TIMER_W'(1);
               if (timer_q == TIMER_W'(WC_CYCLES - 1)) begin
                  doneEv  <= 1'b1;
                  state_q <= S_IDLE;
               end
            end
            default: state_q <= S_IDLE;
         endcase
      end
   end

   eeprom_pin_cycle u_pins (
      .clk     (clk),
      .rst     (rst),
      .cyc     (cyc.pins),
      .ceN     (ceN),
      .oeN     (oeN),
      .weN     (weN),
      .addrPin (addrPin),
      .dataOut (dataOut),
      .dataOe  (dataOe),
      .dataIn  (dataIn)
   );
endmodule
`default_nettype wire

// File: bench/eeprom_host_sva.sv
// Checker on the EEPROM host ports: bus answer and memory strobes.
// Assumes the bind below onto eeprom_host and a single clock domain.
`default_nettype none
module eeprom_host_sva
   import eeprom_host_pkg::*;
(
   // Clock and reset
   input wire logic                               clk,
   input wire logic                               rst,
   // Bus answer
   input wire logic                               hreadyout,
   input wire logic                               hresp,
   // Memory pins
   input wire logic                               ceN,
   input wire logic                               oeN,
   input wire logic                               weN,
   input wire logic [eeprom_host_pkg::ADDR_W-1:0] addrPin,
   input wire logic [eeprom_host_pkg::DATA_W-1:0] dataOut,
   input wire logic                               dataOe
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   bus_ready_a: assert property (!$past(rst) |-> hreadyout && !hresp)
      else $error("bus not ready");
   write_gated_a: assert property (!weN |-> !ceN && oeN && dataOe)
      else $error("strobe ungated");
   read_clean_a: assert property (!oeN |-> !ceN && weN && !dataOe)
      else $error("read contention");
   pulse_width_a: assert property ($fell(weN) |-> !weN [*3] ##1 weN)
      else $error("strobe width");
   latch_hold_a: assert property (!weN |-> $stable(addrPin) && $stable(dataOut))
      else $error("latch moved");
   select_first_a: assert property ($fell(weN) |-> $past(ceN) == 1'b0 && $past(dataOe))
      else $error("select late");
   strobe_first_a: assert property ($rose(weN) |-> !ceN ##1 ceN && !dataOe)
      else $error("release order");
   strobe_gap_a: assert property ($rose(weN) |-> weN [*2])
      else $error("strobe gap");
   cover property ($fell(weN));
   cover property ($fell(oeN));
   cover property (!weN ##[1:200] !oeN);
endmodule

bind eeprom_host eeprom_host_sva chk (.clk(clk), .rst(rst), .hreadyout(hreadyout), .hresp(hresp),
   .ceN(ceN), .oeN(oeN), .weN(weN), .addrPin(addrPin), .dataOut(dataOut), .dataOe(dataOe));
`default_nettype wire

// File: bench/eeprom_model.sv
// Behavioural paged EEPROM on its pins: page load, polling, guard, id bytes.
// Assumes one host on the strobes; times in ns, short windows for the bench.
`default_nettype none
module eeprom_model #(
   parameter int BLC_NS = 1000,
   parameter int WC_NS  = 20000,
   parameter int PWRUP_NS = 200
) (
   // Control pins
   input  wire logic        ceN,
   input  wire logic        oeN,
   input  wire logic        weN,
   input  wire logic        idPin,
   // Address and data
   input  wire logic [14:0] addr,
   input  wire logic [7:0]  hostData,
   output var  logic [7:0]  memData,
   output var  logic        memOe
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0]  mem [0:32831];
   logic [14:0] pa [$];
   logic [7:0]  pd [$];
   logic [14:0] wa;
   logic [7:0]  lastD;
   logic        busy = 0, guard = 0, tog = 0;
   int          n = 0, seen, k;
   time         tf;

   function automatic int ix(input logic [14:0] a);
      return (idPin && a[14:6] == 9'h1FF) ? 32768 + a[5:0] : int'(a);
   endfunction

   initial for (int i = 0; i < 32832; i++) mem[i] = i[7:0] ^ i[14:7];
   always @(negedge weN) begin
      tf = $time;
      if (!ceN && oeN) wa = addr;
   end
   // Spikes under 15 ns never load a byte
   always @(posedge weN) begin
      if (!ceN && oeN && !busy && $time - tf >= 15 && $time >= PWRUP_NS) begin
         pa.push_back(wa);
         pd.push_back(hostData);
         lastD = hostData;
         n++;
      end
   end
   initial forever begin
      wait (n > 0);
      do begin seen = n; #(BLC_NS); end while (seen != n);
      busy = 1;
      k = (pd.size() >= 3 && {pa[0], pd[0], pa[1], pd[1], pa[2], pd[2]} ==
           {15'h5555, 8'hAA, 15'h2AAA, 8'h55, 15'h5555, 8'hA0}) ? 3 : 0;
      if (!guard || k == 3)
         for (int i = k; i < pd.size(); i++) mem[ix(pa[i])] = pd[i];
      pa.delete();
      pd.delete();
      n = 0;
      #(WC_NS);
      guard = guard || k == 3;
      busy = 0;
   end
   assign memOe = !ceN && !oeN && weN;
   assign memData = busy ? {~lastD[7], tog, lastD[5:0]} : mem[ix(addr)];
   always @(posedge oeN) if (busy) tog = ~tog;
endmodule
`default_nettype wire

// File: bench/test_eeprom_host.sv
// Bench for the EEPROM host: bus tasks, page loads, refusals, guard, id area.
// Assumes eeprom_model on the pins and the checker bound by its own file.
`default_nettype none
module test_eeprom_host;
   import eeprom_host_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic              clk = 0, rst = 1, hsel = 0, hwrite = 0, hreadyout, hresp, idOn = 0;
   logic [31:0]       haddr = 0, hwdata = 0, hrdata, rd, st;
   logic [1:0]        htrans = 0;
   logic [2:0]        hsize = 0;
   logic              ceN, oeN, weN, dataOe, idSelect, memOe;
   logic [ADDR_W-1:0] addrPin, a, pg;
   logic [DATA_W-1:0] dataOut, memData, dataIn, v;
   logic [7:0]        shadow [0:32831];
   int                err_total = 0, n_tests = 0, sizes [3] = '{1, 64, 20};

   always #20 clk = ~clk;
   // Released bus shows the inverted memory byte, never the right value
   assign dataIn = dataOe ? dataOut : memOe ? memData : ~memData;
   eeprom_host #(.BLC_CYCLES(64), .WC_CYCLES(2000)) dut (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .ceN(ceN), .oeN(oeN), .weN(weN),
      .addrPin(addrPin), .dataOut(dataOut), .dataOe(dataOe), .dataIn(dataIn), .idSelect(idSelect));
   eeprom_model #(.BLC_NS(1000), .WC_NS(20000)) far (.ceN(ceN), .oeN(oeN), .weN(weN), .idPin(idSelect),
      .addr(addrPin), .hostData(dataOut), .memData(memData), .memOe(memOe));

   function automatic int slot(input logic [14:0] x);
      return (idOn && x[14:6] == 9'h1FF) ? 32768 + x[5:0] : int'(x);
   endfunction
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] want);
      n_tests++;
      if (seen !== want) begin
         err_total++;
         $display("BAD %s expected %h seen %h", name, want, seen);
      end
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic waitReady();
      int k;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (hreadyout !== 1'b1 && k < 100);
      if (k >= 100) begin
         err_total++;
         summarize();
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] d, output logic [31:0] r);
      hsel   <= 1'b1;
      htrans <= HTRANS_NONSEQ;
      hwrite <= w;
      hsize  <= HSIZE_WORD;
      haddr  <= {24'h00_0000, ad};
      waitReady();
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      waitReady();
      r = hrdata;
   endtask
   task automatic wr(input logic [7:0] ad, input logic [31:0] d);
      bus(1'b1, ad, d, rd);
   endtask
   task automatic op(input logic [2:0] cmd, input logic [14:0] x, input logic [7:0] d);
      wr(REG_ADDR, {17'h0_0000, x});
      wr(REG_WDATA, {24'h00_0000, d});
      wr(REG_CMD, {29'h0000_0000, cmd});
   endtask
   task automatic waitBit(input int b);
      int k;
      k = 0;
      do begin
         bus(1'b0, REG_STATUS, 32'h0, st);
         k++;
      end while (st[b] !== 1'b1 && k < 2000);
      if (k >= 2000) begin
         err_total++;
         summarize();
      end
   endtask
   task automatic waitDone();
      waitBit(ST_DONE);
      wr(REG_STATUS, 32'h0000_0F00);
   endtask
   task automatic expectByte(input logic [14:0] x);
      op(CMD_READ, x, 8'h00);
      waitDone();
      bus(1'b0, REG_RDATA, 32'h0, rd);
      check("byte", rd, {24'h00_0000, shadow[slot(x)]});
   endtask

   initial begin
      void'($urandom(32'h0000_EBE6));
      for (int i = 0; i < 32832; i++) shadow[i] = i[7:0] ^ i[14:7];
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      bus(1'b0, REG_STATUS, 32'h0, rd);
      check("status", rd, 32'h0);
      wr(REG_ADDR, 32'hFFFF_FFFF);
      bus(1'b0, REG_ADDR, 32'h0, rd);
      check("addr", rd, 32'h0000_7FFF);
      bus(1'b0, 8'h18, 32'h0, rd);
      check("unmapped", rd, 32'h0);
      for (int i = 0; i < 6; i++) expectByte(i < 2 ? {15{i[0]}} : 15'($urandom));
      foreach (sizes[j]) begin
         pg = 15'($urandom) & 15'h7FC0;
         for (int i = 0; i < sizes[j]; i++) begin
            a = pg | (sizes[j] == 64 ? 15'(63 - i) : 15'($urandom % 64));
            v = 8'($urandom);
            op(CMD_LOAD, a, v);
            shadow[slot(a)] = v;
            // Next byte only once the window is open, else it is refused
            waitBit(ST_OPEN);
         end
         waitDone();
         check("load", st & 32'h0000_0E00, 32'h0);
         for (int i = 0; i < 64; i++) expectByte(pg | 15'(i));
      end
      pg = 15'h1240;
      op(CMD_LOAD, pg, 8'h3C);
      shadow[slot(pg)] = 8'h3C;
      waitBit(ST_OPEN);
      op(CMD_LOAD, pg ^ 15'h0040, 8'hC3);
      bus(1'b0, REG_STATUS, 32'h0, st);
      check("page err", st[ST_ERR_PAGE], 1'b1);
      repeat (100) @(posedge clk);
      wr(REG_CMD, {29'h0000_0000, CMD_READ});
      bus(1'b0, REG_STATUS, 32'h0, st);
      check("busy err", st[ST_ERR_BUSY], 1'b1);
      waitDone();
      expectByte(pg ^ 15'h0040);
      expectByte(pg);
      wr(REG_CMD, {29'h0000_0000, CMD_GUARD_ON});
      waitDone();
      a = 15'h0123;
      v = ~shadow[slot(a)];
      op(CMD_LOAD, a, v);
      waitDone();
      check("guard time", st[ST_ERR_TIME], 1'b1);
      expectByte(a);
      expectByte(15'h5555);
      wr(REG_CONFIG, 32'h0000_0001);
      op(CMD_LOAD, a, v);
      shadow[slot(a)] = v;
      waitDone();
      expectByte(a);
      wr(REG_CONFIG, 32'h0000_0003);
      idOn = 1'b1;
      a = 15'h7FC0 | 15'($urandom % 64);
      v = 8'($urandom);
      op(CMD_LOAD, a, v);
      shadow[slot(a)] = v;
      waitDone();
      expectByte(a);
      expectByte(15'h7FFF);
      wr(REG_CONFIG, 32'h0000_0000);
      idOn = 1'b0;
      expectByte(a);
      summarize();
   end
endmodule
`default_nettype wire
